//--- hw/hib_wake.v
// Always-on hibernation control, wake flags, scratch register and tick trim
`timescale 1ns/100ps
`include "hib_wake_map.vh"
// Function
// - Wake enable bit zero allows alarm wake-up when set.
// - Wake enable reset by pad and hibernate reset, kept over watchdog.
// - Unused wake enable and status bits ignore writes, read zero.
// - Hibernate reset flag bit 5 sets on hibernate reset, sticky.
// - Pad reset flag bit 4 sets on pad reset, sticky.
// - Writing zero clears a status flag, writing one leaves it.
// - Pin flag bit 1 clears on entry, sets on pin wake.
// - Alarm flag bit 0 clears on entry, sets on alarm wake.
// - Pad flag defined after pad reset, hibernate flag after hibernate reset.
// - Thirty-two bit read/write scratch pattern kept in always-on domain.
// - Tick divider counts integer count field plus one cycles.
// - Trim interval fixed at 1024 ticks, deleting programmed clocks.
// - Zero delete count deletes nothing, divider runs on raw clock.
// - Tick rate follows the divider and delete count relation.
// - Slow clock from 32.768 kHz or divided 3.6864 MHz crystal.
// - Writing one to power-down enters hibernation, cutting main power.
// - In hibernation only wake logic runs; wake gives hibernate reset.
// - Hibernate reset requested when any enabled wake source fires.
// - Power-down cleared by pad and hibernate reset; drives power off.
// - Wake pin counts only after persisting programmed 32-cycle units.
module hib_wake #(
  parameter DIV_W = 16,
  parameter ADJ_W = 10,
  parameter FILT_W = 11
) (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire pad_reset_in,
  input wire hibernate_reset_in,
  input wire watchdog_reset_source,
  input wire alarm_match,
  input wire wake_pin,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg main_power_enable_out,
  output reg hib_reset_req,
  output reg slow_tick
);

  // Bus data phase state
  reg wr_pend_reg;
  reg [4:0] wr_addr_reg;
  wire addr_ok;
  wire take;
  assign take = hsel & hready & htrans[1];
  assign addr_ok = (haddr[31:5] == 27'h0) & (haddr[1:0] == 2'h0);

  // Software visible state
  reg [DIV_W-1:0] tick_div_reg;
  reg [ADJ_W-1:0] tick_adj_reg;
  reg power_down_bit;
  reg [FILT_W-1:0] filt_min_reg;
  reg alarm_wake_enable;
  reg hib_reset_flag;
  reg pad_reset_flag;
  reg pin_flag;
  reg alarm_wake_flag;
  reg [31:0] scratch_value;

  // Tick, trim and wake pin filter state
  reg [DIV_W-1:0] div_cnt_reg;
  reg [9:0] trim_tick_reg;
  reg [ADJ_W-1:0] del_left_reg;
  reg [FILT_W+4:0] filt_cnt_reg;
  reg pin_ok_reg;

  wire wr_now;
  reg wr_tick;
  reg wr_ctrl;
  reg wr_filt;
  reg wr_en;
  reg wr_stat;
  reg wr_scr;
  assign wr_now = wr_pend_reg & clk_en;

  // One strobe per register, raised in the data phase of a write
  always @* begin
    wr_tick = 1'b0;
    wr_ctrl = 1'b0;
    wr_filt = 1'b0;
    wr_en = 1'b0;
    wr_stat = 1'b0;
    wr_scr = 1'b0;
    if (wr_now) begin
      case (wr_addr_reg)
        `OFS_TICK_REG: wr_tick = 1'b1;
        `OFS_HIB_CTRL: wr_ctrl = 1'b1;
        `OFS_WAKE_FILT: wr_filt = 1'b1;
        `OFS_WAKE_EN: wr_en = 1'b1;
        `OFS_WAKE_STAT: wr_stat = 1'b1;
        `OFS_SCRATCH: wr_scr = 1'b1;
        default: wr_scr = 1'b0;
      endcase
    end
  end

  // All writes, power-down included, are locked while hibernating
  wire unlocked;
  assign unlocked = ~power_down_bit;

  wire alarm_wake;
  wire pin_wake;
  wire any_wake;
  assign alarm_wake = alarm_match & alarm_wake_enable;
  assign pin_wake = pin_ok_reg;
  assign any_wake = power_down_bit & (alarm_wake | pin_wake);
  wire entering;
  assign entering = wr_ctrl & unlocked & hwdata[`BIT_POWER_DOWN];

  // Read data chosen in the address phase, registered for the data phase
  // Unmapped or unaligned reads return zero rather than an error response
  reg [31:0] hrdata_next;
  always @* begin
    hrdata_next = 32'h0;
    case (haddr[4:0])
      `OFS_TICK_REG: hrdata_next = {6'h0, tick_adj_reg, tick_div_reg};
      `OFS_HIB_CTRL: hrdata_next = {31'h0, power_down_bit};
      `OFS_WAKE_FILT: hrdata_next = {16'h0, filt_min_reg, 5'h00};
      `OFS_WAKE_EN: hrdata_next = {31'h0, alarm_wake_enable};
      `OFS_WAKE_STAT: hrdata_next = {26'h0, hib_reset_flag, pad_reset_flag,
                                     2'b00, pin_flag, alarm_wake_flag};
      `OFS_SCRATCH: hrdata_next = scratch_value;
      default: hrdata_next = 32'h0;
    endcase
    if (!addr_ok) begin
      hrdata_next = 32'h0;
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 5'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      wr_pend_reg <= take & hwrite & addr_ok;
      wr_addr_reg <= haddr[4:0];
      if (take & ~hwrite) begin
        hrdata <= hrdata_next;
      end else if (take) begin
        hrdata <= 32'h0;
      end
    end
  end

  // Hibernate control; reset causes act as synchronous inputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_down_bit <= 1'b0;
    end else if (clk_en) begin
      if (pad_reset_in | hibernate_reset_in) begin
        power_down_bit <= 1'b0;
      end else if (entering) begin
        power_down_bit <= 1'b1;
      end
    end
  end

  // Watchdog leaves the wake enable alone
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_wake_enable <= 1'b0;
    end else if (clk_en) begin
      if (pad_reset_in | hibernate_reset_in) begin
        alarm_wake_enable <= 1'b0;
      end else if (wr_en & unlocked) begin
        alarm_wake_enable <= hwdata[`BIT_ALARM_EN];
      end
    end
  end

  // Power switch drops in the same edge as the power-down write lands
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_power_enable_out <= 1'b1;
      hib_reset_req <= 1'b0;
    end else if (clk_en) begin
      main_power_enable_out <= ~(power_down_bit | entering) |
                               pad_reset_in | hibernate_reset_in;
      hib_reset_req <= any_wake;
    end
  end

  // Wake status flags; a hardware set beats a software clear
  // Status clears are locked out while hibernating, like every other write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_reset_flag <= 1'b0;
    end else if (clk_en) begin
      if (pad_reset_in) begin
        pad_reset_flag <= 1'b1;
      end else if (hibernate_reset_in | watchdog_reset_source) begin
        pad_reset_flag <= 1'b0;
      end else if (wr_stat & unlocked & ~hwdata[`BIT_PAD_FLAG]) begin
        pad_reset_flag <= 1'b0;
      end
    end
  end

  // Watchdog clears both causes; pad reset clears this flag and hibernate reset clears the pad flag
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hib_reset_flag <= 1'b0;
    end else if (clk_en) begin
      if (pad_reset_in) begin
        hib_reset_flag <= 1'b0;
      end else if (hibernate_reset_in) begin
        hib_reset_flag <= 1'b1;
      end else if (watchdog_reset_source) begin
        hib_reset_flag <= 1'b0;
      end else if (wr_stat & unlocked & ~hwdata[`BIT_HIB_FLAG]) begin
        hib_reset_flag <= 1'b0;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_flag <= 1'b0;
    end else if (clk_en) begin
      if (entering) begin
        pin_flag <= 1'b0;
      end else if (any_wake & pin_wake) begin
        pin_flag <= 1'b1;
      end else if (wr_stat & unlocked & ~hwdata[`BIT_PIN_FLAG]) begin
        pin_flag <= 1'b0;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_wake_flag <= 1'b0;
    end else if (clk_en) begin
      if (entering) begin
        alarm_wake_flag <= 1'b0;
      end else if (any_wake & alarm_wake) begin
        alarm_wake_flag <= 1'b1;
      end else if (wr_stat & unlocked & ~hwdata[`BIT_ALARM_FLAG]) begin
        alarm_wake_flag <= 1'b0;
      end
    end
  end

  // Scratch survives pad, hibernate and watchdog resets; only hresetn clears it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scratch_value <= 32'h0;
    end else if (clk_en) begin
      if (wr_scr & unlocked) begin
        scratch_value <= hwdata;
      end
    end
  end

  // Reset divider suits a 32.768 kHz source; other sources need a rewrite
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_div_reg <= `TICK_DIV_RESET;
      tick_adj_reg <= {ADJ_W{1'b0}};
    end else if (clk_en) begin
      if (wr_tick & unlocked) begin
        tick_div_reg <= hwdata[DIV_W-1:0];
        tick_adj_reg <= hwdata[16+ADJ_W-1:16];
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_min_reg <= {FILT_W{1'b0}};
    end else if (clk_en) begin
      if (pad_reset_in | watchdog_reset_source) begin
        filt_min_reg <= {FILT_W{1'b0}};
      end else if (wr_filt & unlocked) begin
        filt_min_reg <= hwdata[5+FILT_W-1:5];
      end
    end
  end

  // Clock deletion: the first clocks of each interval are swallowed
  wire del_now;
  wire tick_now;
  localparam integer TRIM_LAST = `TRIM_PERIOD_TICKS - 1;
  assign del_now = (del_left_reg != {ADJ_W{1'b0}});
  // At or above, so lowering the divider never waits for a counter wrap
  assign tick_now = ~del_now & (div_cnt_reg >= tick_div_reg);

  // Divider holds still while a clock is being swallowed
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= {DIV_W{1'b0}};
      slow_tick <= 1'b0;
    end else if (clk_en) begin
      slow_tick <= tick_now;
      if (tick_now) begin
        div_cnt_reg <= {DIV_W{1'b0}};
      end else if (!del_now) begin
        div_cnt_reg <= div_cnt_reg + 1'b1;
      end
    end
  end

  // Interval counter; the delete count is sampled at the interval's start
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_tick_reg <= 10'h000;
      del_left_reg <= {ADJ_W{1'b0}};
    end else if (clk_en) begin
      if (del_now) begin
        del_left_reg <= del_left_reg - 1'b1;
      end else if (tick_now) begin
        trim_tick_reg <= trim_tick_reg + 1'b1;
        if ({22'h0, trim_tick_reg} == TRIM_LAST) begin
          del_left_reg <= tick_adj_reg;
        end
      end
    end
  end

  // Wake pin filter in units of 32 cycles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_cnt_reg <= {(FILT_W+5){1'b0}};
      pin_ok_reg <= 1'b0;
    end else if (clk_en) begin
      if (!wake_pin) begin
        filt_cnt_reg <= {(FILT_W+5){1'b0}};
        pin_ok_reg <= 1'b0;
      end else if (filt_cnt_reg >= {filt_min_reg, 5'h00}) begin
        pin_ok_reg <= 1'b1;
      end else begin
        filt_cnt_reg <= filt_cnt_reg + 1'b1;
      end
    end
  end

endmodule // hib_wake

//--- hw/hib_wake_map.vh
// Register map, fields, reset values and timing for the hibernate wake block
`ifndef HIB_WAKE_MAP_VH
`define HIB_WAKE_MAP_VH
`define OFS_TICK_REG 5'h00
`define OFS_HIB_CTRL 5'h04
`define OFS_WAKE_FILT 5'h08
`define OFS_WAKE_EN 5'h0c
`define OFS_WAKE_STAT 5'h10
`define OFS_SCRATCH 5'h14
`define BIT_ALARM_EN 0
`define BIT_ALARM_FLAG 0
`define BIT_PIN_FLAG 1
`define BIT_PAD_FLAG 4
`define BIT_HIB_FLAG 5
`define BIT_POWER_DOWN 0
`define TRIM_PERIOD_TICKS 1024
`define TICK_DIV_RESET 16'h7fff
`define FILT_UNIT_CYCLES 32
`endif

//--- test/hib_wake_sva.sv
// Port checker for the hibernate wake block
`timescale 1ns/100ps
`include "hib_wake_map.vh"
module hib_wake_sva (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire pad_reset_in,
  input wire hibernate_reset_in,
  input wire watchdog_reset_source,
  input wire alarm_match,
  input wire wake_pin,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire main_power_enable_out,
  input wire hib_reset_req
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire quiet = clk_en && !pad_reset_in && !hibernate_reset_in && !watchdog_reset_source;
  wire pd_addr = hsel && hready && htrans[1] && hwrite && clk_en &&
    haddr == {27'h0, `OFS_HIB_CTRL};
  ready_high_a: assert property (hreadyout) else $error("hreadyout low");
  resp_okay_a: assert property (!hresp) else $error("hresp not okay");
  pad_power_a: assert property (clk_en && pad_reset_in |=> main_power_enable_out)
    else $error("power off after pad reset");
  hib_power_a: assert property (clk_en && hibernate_reset_in |=> main_power_enable_out)
    else $error("power off after hibernate reset");
  power_down_a: assert property (pd_addr ##1 (hwdata[0] && quiet) |=> ##[0:1] !main_power_enable_out)
    else $error("power down write ignored");
  power_held_a: assert property (!main_power_enable_out && quiet |=> !main_power_enable_out)
    else $error("power returned without reset");
  wake_quiet_a: assert property (main_power_enable_out && $past(main_power_enable_out) |-> !hib_reset_req)
    else $error("wake request while powered");
  wake_cause_a: assert property (hib_reset_req && $past(clk_en) |->
    $past(!main_power_enable_out) && ($past(alarm_match) || $past(wake_pin)))
    else $error("wake request without source");
  cover property (!main_power_enable_out);
  cover property (hib_reset_req);
  cover property (pad_reset_in);
endmodule // hib_wake_sva
bind hib_wake hib_wake_sva i_sva (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
  .pad_reset_in(pad_reset_in), .hibernate_reset_in(hibernate_reset_in),
  .watchdog_reset_source(watchdog_reset_source), .alarm_match(alarm_match),
  .wake_pin(wake_pin), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .main_power_enable_out(main_power_enable_out), .hib_reset_req(hib_reset_req));

//--- test/rtc_hibernate_wakeup_trim_test.sv
// Self-checking bench for the hibernate wake block
`timescale 1ns/100ps
`include "hib_wake_map.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module rtc_hibernate_wakeup_trim_test;
  logic hclk = 1'h0, hresetn = 1'h0, hwrite = 1'h0, fire_alarm = 1'h0, fire_pin = 1'h0;
  logic pad_reset_in = 1'h0, hibernate_reset_in = 1'h0, watchdog_reset_source = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  wire [31:0] hrdata;
  wire hreadyout, hresp, main_power_enable_out, hib_reset_req, slow_tick;
  wire alarm_match, wake_pin, core_powered;
  int bad_count = 0, total_checks = 0, n, acc;
  always #2.5 hclk = ~hclk;
  hib_wake i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'h1), .pad_reset_in(pad_reset_in),
    .hibernate_reset_in(hibernate_reset_in), .watchdog_reset_source(watchdog_reset_source),
    .alarm_match(alarm_match), .wake_pin(wake_pin), .hsel(1'h1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .slow_tick(slow_tick),
    .main_power_enable_out(main_power_enable_out), .hib_reset_req(hib_reset_req));
  wake_source_model i_wake (.hclk(hclk), .main_power_enable_out(main_power_enable_out),
    .fire_alarm(fire_alarm), .fire_pin(fire_pin), .alarm_match(alarm_match),
    .wake_pin(wake_pin), .core_powered(core_powered));
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    htrans <= 2'h2; haddr <= {27'h0, a}; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  task automatic pulse(input int k);
    case (k) 0: pad_reset_in <= 1'h1; 1: hibernate_reset_in <= 1'h1;
      default: watchdog_reset_source <= 1'h1; endcase
    @(posedge hclk);
    {pad_reset_in, hibernate_reset_in, watchdog_reset_source} <= 3'h0;
    @(posedge hclk);
  endtask
  task automatic wait_on(input logic tick, input int lim);
    n = 0;
    do begin @(posedge hclk); n++; end
    while (n < lim && (tick ? slow_tick : hib_reset_req) !== 1'h1);
  endtask
  task automatic t_regs;
    xfer(1, `OFS_SCRATCH, 32'ha5c3_0f96); xfer(0, `OFS_SCRATCH, 32'h0);
    `CHK("scratch", 32'ha5c3_0f96, rd)
    xfer(1, `OFS_WAKE_EN, 32'hffff_ffff); xfer(0, `OFS_WAKE_EN, 32'h0);
    `CHK("wake_en", 32'h1, rd)
    pulse(2); xfer(0, `OFS_WAKE_EN, 32'h0);
    `CHK("en_wdog", 32'h1, rd)
    pulse(0); xfer(0, `OFS_WAKE_EN, 32'h0);
    `CHK("en_pad", 32'h0, rd)
    xfer(1, `OFS_WAKE_STAT, 32'hffff_ffff); xfer(0, `OFS_WAKE_STAT, 32'h0);
    `CHK("pad_flag", 1'h1, rd[4])
    `CHK("stat_unused", 28'h0, {rd[31:6], rd[3:2]})
    xfer(1, `OFS_WAKE_STAT, 32'h0); xfer(0, `OFS_WAKE_STAT, 32'h0);
    `CHK("pad_clear", 1'h0, rd[4])
  endtask
  task automatic t_alarm;
    xfer(1, `OFS_WAKE_EN, 32'h1);
    xfer(1, `OFS_HIB_CTRL, 32'h1);
    repeat (3) @(posedge hclk);
    `CHK("power_off", 1'h0, core_powered)
    xfer(1, `OFS_SCRATCH, 32'h0); xfer(0, `OFS_SCRATCH, 32'h0);
    `CHK("locked", 32'ha5c3_0f96, rd)
    xfer(0, `OFS_WAKE_STAT, 32'h0);
    `CHK("entry_clear", 2'h0, rd[1:0])
    fire_alarm <= 1'h1; wait_on(0, 10);
    `CHK("alarm_req", 1'h1, hib_reset_req)
    fire_alarm <= 1'h0; pulse(1);
    `CHK("power_on", 1'h1, main_power_enable_out)
    xfer(0, `OFS_WAKE_STAT, 32'h0);
    `CHK("hib_alarm", 2'h3, {rd[5], rd[0]})
    xfer(0, `OFS_WAKE_EN, 32'h0);
    `CHK("en_hib", 32'h0, rd)
  endtask
  task automatic t_pin;
    xfer(1, `OFS_WAKE_FILT, 32'h20);
    xfer(1, `OFS_HIB_CTRL, 32'h1);
    {fire_alarm, fire_pin} <= 2'h3;
    repeat (20) @(posedge hclk);
    `CHK("pin_early", 1'h0, hib_reset_req)
    wait_on(0, 60);
    `CHK("pin_req", 1'h1, hib_reset_req)
    {fire_alarm, fire_pin} <= 2'h0; pulse(1);
    xfer(0, `OFS_WAKE_STAT, 32'h0);
    `CHK("pin_flag", 2'h2, rd[1:0])
  endtask
  task automatic t_tick;
    xfer(1, `OFS_TICK_REG, 32'h3);
    wait_on(1, 40000); wait_on(1, 100);
    `CHK("tick_gap", 4, n)
    xfer(1, `OFS_TICK_REG, 32'h0005_0003);
    wait_on(1, 100); acc = 0;
    repeat (1024) begin wait_on(1, 100); acc += n; end
    `CHK("trim_span", (1 << 10) * (3 + 1) + 5, acc)
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_regs; t_alarm; t_pin; t_tick;
    wrap_up;
  end
  // Whole run is a few thousand cycles, most of it the trim span
  initial begin
    repeat (60000) @(posedge hclk);
    bad_count++;
    wrap_up;
  end
endmodule // rtc_hibernate_wakeup_trim_test

//--- test/wake_source_model.sv
// Alarm, wake pin and main power switch outside the block
`timescale 1ns/100ps
module wake_source_model (
  input wire hclk,
  input wire main_power_enable_out,
  input wire fire_alarm,
  input wire fire_pin,
  output logic alarm_match = 1'b0,
  output logic wake_pin = 1'b0,
  output logic core_powered = 1'b1
);
  // Switch follows the enable one cycle late, like a slow regulator
  always @(posedge hclk) begin
    alarm_match <= fire_alarm;
    wake_pin <= fire_pin;
    core_powered <= main_power_enable_out;
  end
endmodule // wake_source_model
